// *** include/asc_pkg.sv ***
// package: constants for the async sram host controller
package asc_pkg;
    localparam int ADDR_W = 18;              // 256K words
    localparam int DATA_W = 16;              // word width
    localparam int CLK_PS = 5000;            // ref clock period in ps
    // timing figures in ns, as the memory needs them (55 ns grade)
    localparam int T_RC_NS = 55;             // read cycle / address access
    localparam int T_DOE_NS = 25;            // output enable access
    localparam int T_PWE_NS = 40;            // write strobe pulse width
    localparam int T_SD_NS = 25;             // data setup to write end
    localparam int T_HZWE_NS = 20;           // outputs float after write strobe low
    localparam int T_LZWE_NS = 5;            // outputs quiet after write strobe high
    localparam int T_WC_NS = 55;             // write cycle time
    // least times round up to whole cycles
    localparam int RD_CYC = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WE_CYC = (T_PWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SD_CYC = (T_SD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int HZ_CYC = (T_HZWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int LZ_CYC = (T_LZWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WC_CYC = (T_WC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 5;                // wide enough for all counts
    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_READ,
        ASC_WR_FLOAT,
        ASC_WR_STROBE,
        ASC_WR_RECOVER
    } asc_state_e;
endpackage

// *** hdl/asc_ctrl.sv ***
// host controller driving an asynchronous 256Kx16 static memory by its pins
// How it works
// RQ1 - eighteen-bit word address, sixteen-bit data
// RQ2 - no refresh; memory needs no clock
// RQ3 - idle keeps chip deselected, bytes disabled one cycle after select rises
// RQ4 - byte enables gate each data lane
// RQ5 - read: write high, select low, output low
// RQ6 - held read follows address without strobing
// RQ7 - address stable before select falls; here address and select change on the same edge
// RQ8 - write when select, write, byte overlap
// RQ9 - write ends by raising write strobe
// RQ10 - data held stable across terminating edge
// RQ11 - wait float time before driving bus
// RQ12 - select with outputs off never writes
// RQ13 - output enable held high during writes
`timescale 1ns/10ps
module asc_ctrl (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic req_valid_in,                 // request strobe
    input wire logic req_write_in,                 // 1 write, 0 read
    input wire logic req_follow_in,                // read stays open for follow-on addresses
    input wire logic [17:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic [1:0] req_byte_in,            // bit0 lower lane, bit1 upper lane
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_rdata_out,
    output logic [17:0] word_address_out,
    output logic chip_select_n_out,
    output logic output_enable_n_out,
    output logic write_enable_n_out,
    output logic lower_byte_enable_n_out,
    output logic upper_byte_enable_n_out,
    input wire logic [15:0] data_lines_in,
    output logic [15:0] data_lines_out,
    output logic [1:0] data_lines_oe_out           // per lane, high while we drive
);
    ////////////////////////////////////////////////////////////////////
    asc_pkg::asc_state_e state_reg;                // sequencer state
    logic [asc_pkg::CNT_W-1:0] cnt_reg;            // cycles in current state; float and strobe phases share one count
    logic write_reg;                               // current op is a write
    logic follow_reg;                              // open read mode
    logic [1:0] lanes_reg;                         // enabled lanes, active high
    logic [15:0] wdata_reg;                        // held write data
    logic take;                                    // request accepted now

    // accept only between operations, or re-address an open read
    assign req_ready_out = (state_reg == asc_pkg::ASC_IDLE) ||
                           (state_reg == asc_pkg::ASC_READ && follow_reg && !req_write_in &&
                            cnt_reg >= asc_pkg::CNT_W'(asc_pkg::RD_CYC));
    assign take = req_valid_in && req_ready_out;

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            state_reg <= asc_pkg::ASC_IDLE;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                asc_pkg::ASC_IDLE: begin
                    cnt_reg <= '0;
                    if (take) begin
                        // writes first let the memory float its outputs
                        state_reg <= req_write_in ? asc_pkg::ASC_WR_FLOAT
                                                  : asc_pkg::ASC_READ;
                    end
                end
                asc_pkg::ASC_READ: begin
                    if (take) begin
                        cnt_reg <= '0;                                    // RQ6
                    end else if (cnt_reg >= asc_pkg::CNT_W'(asc_pkg::RD_CYC)) begin
                        if (!follow_reg || !req_valid_in || req_write_in) begin
                            state_reg <= asc_pkg::ASC_IDLE;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                asc_pkg::ASC_WR_FLOAT: begin
                    // strobe already low; bus stays ours only after float time
                    if (cnt_reg >= asc_pkg::CNT_W'(asc_pkg::HZ_CYC - 1)) begin
                        state_reg <= asc_pkg::ASC_WR_STROBE;
                    end
                    cnt_reg <= cnt_reg + 1'b1;
                end
                asc_pkg::ASC_WR_STROBE: begin
                    // strobe held for write cycle time WC_CYC counted from strobe low, which covers pulse width and data setup
                    if (cnt_reg >= asc_pkg::CNT_W'(asc_pkg::WC_CYC - 1)) begin
                        state_reg <= asc_pkg::ASC_WR_RECOVER;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                asc_pkg::ASC_WR_RECOVER: begin
                    // strobe high, data still driven for hold, then settle
                    if (cnt_reg >= asc_pkg::CNT_W'(asc_pkg::LZ_CYC)) begin
                        state_reg <= asc_pkg::ASC_IDLE;
                    end
                    cnt_reg <= cnt_reg + 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request capture; address held for the whole access
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            write_reg <= 1'b0;
            follow_reg <= 1'b0;
            lanes_reg <= 2'h0;
            wdata_reg <= 16'h0000;
        end else if (take) begin
            write_reg <= req_write_in;
            follow_reg <= req_follow_in && !req_write_in;
            // no lane chosen would be standby; treat as full word
            lanes_reg <= (req_byte_in == 2'h0) ? 2'h3 : req_byte_in;     // RQ4
            wdata_reg <= req_wdata_in;
        end
    end

    // address has no reset: a reset that cuts a write must not move the
    // address under the closing strobe, or the torn write lands on word zero
    always_ff @(posedge ref_clk_in) begin
        if (nrst_in && take) begin
            word_address_out <= req_addr_in;                             // RQ1 RQ7
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin strobes, registered so no glitches reach the memory
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            chip_select_n_out <= 1'b1;                                   // RQ3
            output_enable_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
            lower_byte_enable_n_out <= 1'b1;
            upper_byte_enable_n_out <= 1'b1;
            data_lines_oe_out <= 2'h0;
            data_lines_out <= 16'h0000;
        end else begin
            // select falls on the same edge that sets the address
            chip_select_n_out <= !(state_reg != asc_pkg::ASC_IDLE ||
                                   (take && state_reg == asc_pkg::ASC_IDLE)) ||
                                 (state_reg == asc_pkg::ASC_IDLE && !take) ||
                                 (state_reg == asc_pkg::ASC_WR_RECOVER &&
                                  cnt_reg >= asc_pkg::CNT_W'(asc_pkg::LZ_CYC)) ||
                                 (state_reg == asc_pkg::ASC_READ && !take &&
                                  cnt_reg >= asc_pkg::CNT_W'(asc_pkg::RD_CYC) &&
                                  (!follow_reg || !req_valid_in || req_write_in));  // RQ3 RQ7
            // output enable only for reads, never during writes
            output_enable_n_out <= !(take ? !req_write_in
                                          : (state_reg == asc_pkg::ASC_READ &&
                                             !(cnt_reg >= asc_pkg::CNT_W'(asc_pkg::RD_CYC) &&
                                               (!follow_reg || !req_valid_in ||
                                                req_write_in))));           // RQ5 RQ13 RQ12
            // write strobe low across float and strobe phases
            write_enable_n_out <= !((take && req_write_in) ||
                                    state_reg == asc_pkg::ASC_WR_FLOAT ||
                                    (state_reg == asc_pkg::ASC_WR_STROBE &&
                                     cnt_reg < asc_pkg::CNT_W'(asc_pkg::WC_CYC - 1)));  // RQ8 RQ9
            if (take) begin
                lower_byte_enable_n_out <= !(req_byte_in[0] || req_byte_in == 2'h0);
                upper_byte_enable_n_out <= !(req_byte_in[1] || req_byte_in == 2'h0);
            end else if (chip_select_n_out) begin
                lower_byte_enable_n_out <= 1'b1;
                upper_byte_enable_n_out <= 1'b1;
            end
            // drive bus only after memory floated, release after hold
            if (state_reg == asc_pkg::ASC_WR_FLOAT &&
                cnt_reg >= asc_pkg::CNT_W'(asc_pkg::HZ_CYC - 1)) begin
                data_lines_oe_out <= lanes_reg;                          // RQ11 RQ4
                data_lines_out <= wdata_reg;                             // RQ10
            end else if (state_reg == asc_pkg::ASC_WR_RECOVER) begin
                data_lines_oe_out <= 2'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data capture after access time; lanes not read show zero
    always_ff @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 16'h0000;
        end else begin
            rsp_valid_out <= 1'b0;
            if (state_reg == asc_pkg::ASC_READ && !take &&
                cnt_reg == asc_pkg::CNT_W'(asc_pkg::RD_CYC - 1)) begin
                rsp_valid_out <= 1'b1;
                rsp_rdata_out <= data_lines_in &
                                 {{8{lanes_reg[1]}}, {8{lanes_reg[0]}}};  // RQ5 RQ6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_strobe_fall;
        $fell(write_enable_n_out);
    endsequence
    sequence s_float_wait;
        !(|data_lines_oe_out) [*3];
    endsequence
    property p_float;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_strobe_fall |-> s_float_wait;
    endproperty
    a_float: assert property (p_float) else $error("bus driven before float time"); // RQ11
    property p_no_oe_write;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !write_enable_n_out |-> output_enable_n_out;
    endproperty
    a_no_oe_write: assert property (p_no_oe_write) else $error("oe low in write"); // RQ13
    property p_hold;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        $rose(write_enable_n_out) |-> (|data_lines_oe_out) && $stable(data_lines_out);
    endproperty
    a_hold: assert property (p_hold) else $error("data not held at write end"); // RQ10
    property p_addr;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        // address set and select fall on one edge: coincident is allowed
        $fell(chip_select_n_out) |-> word_address_out == $past(req_addr_in);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved at select"); // RQ7
    property p_write_sel;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !write_enable_n_out |-> !chip_select_n_out &&
            !(lower_byte_enable_n_out && upper_byte_enable_n_out);
    endproperty
    a_write_sel: assert property (p_write_sel) else $error("write strobe unqualified"); // RQ8
endmodule

// *** sim/asc_sram_model.sv ***
// behavioural model of the asynchronous 256Kx16 static memory
`timescale 1ns/10ps
module asc_sram_model #(
    parameter int ACC_NS = 50 // access delay, near the slow end
) (
    input wire logic [17:0] word_address_in,
    input wire logic chip_select_n_in,
    input wire logic output_enable_n_in,
    input wire logic write_enable_n_in,
    input wire logic lower_byte_enable_n_in,
    input wire logic upper_byte_enable_n_in,
    input wire logic [15:0] host_data_in, // what the host puts on the lines
    input wire logic [1:0] host_oe_in, // host lane drive
    output logic [15:0] bus_out, // resolved data lines
    output logic [1:0] drive_out // lanes driven by memory
);
    ////////////////////////////////////////////////////////////////
    logic [15:0] mem [0:262143];
    logic [15:0] junk = 16'h5a5a; // floating lines, never a stale value
    logic [1:0] lanes_q; // lanes seen while writing
    logic rd_dly; // read access delayed
    logic rd;
    logic wr;
    logic [1:0] lanes;
    assign lanes = {~upper_byte_enable_n_in, ~lower_byte_enable_n_in};
    assign rd = ~chip_select_n_in & ~output_enable_n_in & write_enable_n_in;
    assign wr = ~chip_select_n_in & ~write_enable_n_in & (lanes != 2'h0);
    assign #(ACC_NS) rd_dly = rd;
    // release at once when deselected or write strobe low
    assign drive_out = (rd & rd_dly) ? lanes : 2'h0;
    // released lines toggle so the host cannot lean on them
    always #5 junk = ~junk;
    ////////////////////////////////////////////////////////////////
    // lane mux; host wins so contention still shows in the bench
    always @* begin
        for (int k = 0; k < 2; k++) begin
            bus_out[k*8+:8] = host_oe_in[k] ? host_data_in[k*8+:8] :
                drive_out[k] ? mem[word_address_in][k*8+:8] : junk[k*8+:8];
        end
    end
    // track lanes while the write is open
    always @(lanes or wr) begin
        if (wr) begin
            lanes_q = lanes;
        end
    end
    // data taken at whichever strobe ends the write
    always @(negedge wr) begin
        for (int k = 0; k < 2; k++) begin
            if (lanes_q[k]) begin
                mem[word_address_in][k*8+:8] = bus_out[k*8+:8];
            end
        end
    end
endmodule

// *** sim/asc_ctrl_tb.sv ***
// self-checking bench for the async sram host controller
`timescale 1ns/10ps
module asc_ctrl_tb;
    logic ref_clk_in = 1'b0; // 200 MHz
    logic nrst_in = 1'b0;
    logic rv, rw, rf;
    logic [17:0] ra;
    logic [15:0] rd;
    logic [1:0] rb;
    logic rdy, vld, cs_n, oe_n, we_n, lb_n, ub_n;
    logic [15:0] rdata, dout, bus;
    logic [17:0] wa;
    logic [1:0] doe, mdrv;
    int err_count = 0;
    int compares = 0;
    int lat;
    // rows: write, lanes, address, write data, expected read data
    localparam logic [52:0] ROWS [8] = '{
        {1'b1, 2'h3, 18'h00000, 16'h1234, 16'h0000},
        {1'b1, 2'h0, 18'h3ffff, 16'habcd, 16'h0000},
        {1'b1, 2'h1, 18'h3ffff, 16'h5566, 16'h0000},
        {1'b1, 2'h2, 18'h00000, 16'h9900, 16'h0000},
        {1'b0, 2'h3, 18'h00000, 16'h0000, 16'h9934},
        {1'b0, 2'h1, 18'h3ffff, 16'h0000, 16'h0066},
        {1'b0, 2'h2, 18'h3ffff, 16'h0000, 16'hab00},
        {1'b0, 2'h0, 18'h3ffff, 16'h0000, 16'hab66}};
    always #2.5 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////////////////////////////////////
    asc_ctrl asc_ctrl_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .req_valid_in(rv),
        .req_write_in(rw), .req_follow_in(rf), .req_addr_in(ra), .req_wdata_in(rd),
        .req_byte_in(rb), .req_ready_out(rdy), .rsp_valid_out(vld), .rsp_rdata_out(rdata),
        .word_address_out(wa), .chip_select_n_out(cs_n), .output_enable_n_out(oe_n),
        .write_enable_n_out(we_n), .lower_byte_enable_n_out(lb_n),
        .upper_byte_enable_n_out(ub_n), .data_lines_in(bus), .data_lines_out(dout),
        .data_lines_oe_out(doe));
    asc_sram_model asc_sram_model_inst (.word_address_in(wa), .chip_select_n_in(cs_n),
        .output_enable_n_in(oe_n), .write_enable_n_in(we_n), .lower_byte_enable_n_in(lb_n),
        .upper_byte_enable_n_in(ub_n), .host_data_in(dout), .host_oe_in(doe),
        .bus_out(bus), .drive_out(mdrv));
    ////////////////////////////////////////////////////////////////
    task cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cmp1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task stop_test;
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task tick;
        @(posedge ref_clk_in);
        #1;
    endtask
    // one request; ready is settled between edges, so test it before the edge
    task req(input logic w, f, input logic [1:0] b, input logic [17:0] a,
        input logic [15:0] d, output int n);
        n = 0;
        while (rdy !== 1'b1) begin
            tick;
            n++;
            if (n > 200) begin
                cmp1("ready wait", 1'b1, 1'b0);
                stop_test;
            end
        end
        {rv, rw, rf, rb, ra, rd} = {1'b1, w, f, b, a, d};
        tick;
        rv = 1'b0;
        n = 1;
        while (!w && vld !== 1'b1) begin
            tick;
            n++;
            if (n > 200) begin
                cmp1("response wait", 1'b1, 1'b0);
                stop_test;
            end
        end
    endtask
    // memory and host must never drive one lane together
    always @(posedge ref_clk_in) begin
        if (nrst_in && (doe & mdrv) != 2'h0) cmp1("lane contention", 1'b0, 1'b1);
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {rv, rw, rf, rb, ra, rd} = '0;
        repeat (20) @(posedge ref_clk_in);
        #1 nrst_in = 1'b1;
        cmp1("select idle", 1'b1, cs_n);
        cmp16("lane drive idle", 16'h0, {14'h0, doe});
        // table: writes per lane, then masked reads
        foreach (ROWS[i]) begin
            req(ROWS[i][52], 1'b0, ROWS[i][51:50], ROWS[i][49:32], ROWS[i][31:16], lat);
            if (!ROWS[i][52]) begin
                cmp16("read data", ROWS[i][15:0], rdata);
                cmp1("read latency", 1'b1, lat >= asc_pkg::RD_CYC);
            end
        end
        // open read re-addressed without strobing
        req(1'b0, 1'b1, 2'h0, 18'h00000, 16'h0, lat);
        cmp16("open read first", 16'h9934, rdata);
        cmp1("select held", 1'b0, cs_n);
        req(1'b0, 1'b0, 2'h0, 18'h3ffff, 16'h0, lat);
        cmp16("open read second", 16'hab66, rdata);
        // reset in the middle of a write
        req(1'b1, 1'b0, 2'h3, 18'h00055, 16'hc3c3, lat);
        repeat (3) tick;
        nrst_in = 1'b0;
        repeat (2) tick;
        cmp1("write strobe reset", 1'b1, we_n);
        cmp1("select reset", 1'b1, cs_n);
        nrst_in = 1'b1;
        req(1'b0, 1'b0, 2'h3, 18'h00000, 16'h0, lat);
        cmp16("neighbour kept", 16'h9934, rdata);
        stop_test;
    end
endmodule
